// File: shared/verify_seq_params.svh
// Status codes, address layout and block geometry of the verify sequencer
`ifndef VERIFY_SEQ_PARAMS_SVH
`define VERIFY_SEQ_PARAMS_SVH
`define ADDR_W 24
`define BLOCK_LOG2 12
`define CODE_PARAM 8'h05
`define CODE_ACK 8'h06
`define CODE_CSUM 8'h07
`define CODE_MISMATCH 8'h0f
`define CODE_NACK 8'h15
`define ZERO_CODE 8'h00
`endif

// File: shared/verify_seq_pkg.sv
// Types carried between the frame link and the verify sequencer
`include "verify_seq_params.svh"
package verify_seq_pkg;
   typedef struct packed {
      logic [`ADDR_W-1:0] start_addr;
      logic [`ADDR_W-1:0] end_addr;
      logic length_ok;
      logic end_marker_ok;
      logic checksum_ok;
   } cmd_frame_t;
   typedef struct packed {
      logic [7:0] data;
      logic last_byte;
      logic end_frame;
      logic checksum_ok;
   } data_beat_t;
   typedef struct packed {
      logic [7:0] first_status_byte;
      logic [7:0] second_status_byte;
      logic two_bytes;
   } status_frame_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DATA = 2'b10
   } seq_state_t;
endpackage

// File: hdl/flash_verify_command_sequencer.sv
// Device-side sequencer for the flash verify command exchange
//
// What this block does
// - Idle device answers command with status; only acknowledge opens data phase.
// - Device returns both status bytes after every data frame, unless a command arrives with its last byte.
// - Both acknowledge: await next frame; after end frame sequence completes.
// - Frame with data or checksum mismatch reports code in second byte.
// - Success and matching data reported with the acknowledge code.
// - Start or end address off block boundary gives parameter error.
// - Malformed command frame gives negative acknowledge.
// - Bad command checksum gives checksum error in first byte.
`timescale 1ns/1ps
`include "verify_seq_params.svh"
module flash_verify_command_sequencer
   import verify_seq_pkg::*;
(
   input wire logic mclk, // 10 MHz clock
   input wire logic reset, // Synchronous, active high
   input wire logic cmd_valid, // Verify command frame received, pulse
   input wire cmd_frame_t cmd_frame, // Decoded command frame
   input wire logic data_valid, // One reference byte, pulse
   input wire data_beat_t data_beat, // Reference byte and frame flags
   input wire logic [7:0] flash_rdata, // Flash byte at flash_addr
   output logic [`ADDR_W-1:0] flash_addr, // Address being compared
   output logic status_valid, // Status frame ready, pulse
   output status_frame_t status_frame, // Status bytes to send
   output logic busy // Data phase open
);
   seq_state_t state_q;
   logic [`ADDR_W-1:0] addr_q;
   logic [`ADDR_W-1:0] end_q;
   logic past_end_q;
   logic mism_q;
   logic status_valid_q;
   status_frame_t status_q;
   logic busy_q;
   logic [`BLOCK_LOG2-1:0] ones;
   logic param_bad;
   logic byte_bad;
   logic frame_bad;
   logic frame_done;
   logic frame_ok;

   assign ones = '1;
   // Block alignment: start on first byte, end on last byte of a block
   assign param_bad = (cmd_frame.start_addr[`BLOCK_LOG2-1:0] != '0)
      || (cmd_frame.end_addr[`BLOCK_LOG2-1:0] != ones)
      || (cmd_frame.end_addr < cmd_frame.start_addr);
   // Bytes past the range, or an end frame short of it, count as mismatch
   assign byte_bad = (data_beat.data != flash_rdata) || past_end_q
      || (data_beat.last_byte && data_beat.end_frame && addr_q != end_q);
   assign frame_bad = mism_q || byte_bad;
   assign frame_done = (state_q == ST_DATA) && data_valid
      && data_beat.last_byte;
   assign frame_ok = frame_done && data_beat.checksum_ok && !frame_bad;

   always_ff @(posedge mclk) begin
      // Busy is its own flop so the pin never comes from decode logic
      if (reset) begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cmd_valid && cmd_frame.length_ok
                   && cmd_frame.end_marker_ok && cmd_frame.checksum_ok
                   && !param_bad) begin
                  state_q <= ST_DATA;
                  busy_q <= 1'b1;
               end
            end
            ST_DATA: begin
               // A fresh command aborts to idle and is not taken; the programmer never retries
               if (cmd_valid) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
               end else if (frame_done) begin
                  if (!frame_ok || data_beat.end_frame) begin
                     state_q <= ST_IDLE;
                     busy_q <= 1'b0;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // Address parks on the end so an overrun byte is flagged, not read
   always_ff @(posedge mclk) begin
      if (reset) begin
         addr_q <= '0;
         end_q <= '0;
         past_end_q <= 1'b0;
         mism_q <= 1'b0;
      end else if (state_q == ST_IDLE && cmd_valid) begin
         addr_q <= cmd_frame.start_addr;
         end_q <= cmd_frame.end_addr;
         past_end_q <= 1'b0;
         mism_q <= 1'b0;
      end else if (state_q == ST_DATA && data_valid) begin
         if (addr_q == end_q) begin
            past_end_q <= 1'b1;
         end else begin
            addr_q <= addr_q + `ADDR_W'(1);
         end
         mism_q <= data_beat.last_byte ? 1'b0 : frame_bad;
      end
   end

   // A command in the data phase aborts it and draws no reply
   always_ff @(posedge mclk) begin
      if (reset) begin
         status_valid_q <= 1'b0;
         status_q <= '0;
      end else begin
         status_valid_q <= 1'b0;
         if (state_q == ST_IDLE && cmd_valid) begin
            status_valid_q <= 1'b1;
            status_q.two_bytes <= 1'b0;
            status_q.second_status_byte <= `ZERO_CODE;
            if (!cmd_frame.length_ok || !cmd_frame.end_marker_ok) begin
               status_q.first_status_byte <= `CODE_NACK;
            end else if (!cmd_frame.checksum_ok) begin
               status_q.first_status_byte <= `CODE_CSUM;
            end else if (param_bad) begin
               status_q.first_status_byte <= `CODE_PARAM;
            end else begin
               status_q.first_status_byte <= `CODE_ACK;
            end
         end else if (frame_done && !cmd_valid) begin
            status_valid_q <= 1'b1;
            status_q.two_bytes <= 1'b1;
            status_q.first_status_byte <= `CODE_ACK;
            if (!data_beat.checksum_ok) begin
               status_q.second_status_byte <= `CODE_CSUM;
            end else if (frame_bad) begin
               status_q.second_status_byte <= `CODE_MISMATCH;
            end else begin
               status_q.second_status_byte <= `CODE_ACK;
            end
         end
      end
   end

   assign flash_addr = addr_q;
   assign status_valid = status_valid_q;
   assign status_frame = status_q;
   assign busy = busy_q;

   // One clock domain, so the checks share a default clock and reset
   default clocking chk_clk @(posedge mclk);
   endclocking
   default disable iff (reset);

   chk_cmd_reply: assert property (
      state_q == ST_IDLE && cmd_valid |=> status_valid
      && !status_frame.two_bytes) else $error("no command reply");
   chk_ack_opens: assert property (
      state_q == ST_IDLE && cmd_valid
      |=> busy == (status_frame.first_status_byte == `CODE_ACK))
      else $error("data phase not tied to acknowledge");
   chk_idle_quiet: assert property (
      state_q == ST_IDLE && !cmd_valid |=> !status_valid)
      else $error("reply without a command");
   chk_data_two_bytes: assert property (
      frame_done && !cmd_valid |=> status_valid && status_frame.two_bytes
      && status_frame.first_status_byte == `CODE_ACK)
      else $error("data reply lacks two bytes");
   chk_mismatch_code: assert property (
      frame_done && !cmd_valid && data_beat.checksum_ok
      && data_beat.data != flash_rdata
      |=> status_frame.second_status_byte == `CODE_MISMATCH && !busy)
      else $error("mismatch not reported");
   chk_overrun_code: assert property (
      frame_done && !cmd_valid && data_beat.checksum_ok && past_end_q
      |=> status_frame.second_status_byte == `CODE_MISMATCH && !busy)
      else $error("overrun not reported");
   chk_data_csum: assert property (
      frame_done && !cmd_valid && !data_beat.checksum_ok
      |=> status_frame.second_status_byte == `CODE_CSUM && !busy)
      else $error("data checksum error missed");
   chk_ack_code: assert property (
      status_valid && status_frame.two_bytes
      && status_frame.second_status_byte == `CODE_ACK
      |-> $past(frame_done) && $past(data_beat.checksum_ok)
      && !$past(frame_bad)) else $error("acknowledge on bad frame");
   chk_param_code: assert property (
      state_q == ST_IDLE && cmd_valid && cmd_frame.length_ok
      && cmd_frame.end_marker_ok && cmd_frame.checksum_ok
      && cmd_frame.start_addr[`BLOCK_LOG2-1:0] != '0
      |=> status_frame.first_status_byte == `CODE_PARAM && !busy)
      else $error("parameter error missed");
   chk_nack_code: assert property (
      state_q == ST_IDLE && cmd_valid && !cmd_frame.end_marker_ok
      |=> status_frame.first_status_byte == `CODE_NACK && !busy)
      else $error("nack missed");
   chk_csum_code: assert property (
      state_q == ST_IDLE && cmd_valid && cmd_frame.length_ok
      && cmd_frame.end_marker_ok && !cmd_frame.checksum_ok
      |=> status_frame.first_status_byte == `CODE_CSUM)
      else $error("command checksum error missed");
   chk_end_return: assert property (
      frame_ok && !cmd_valid && data_beat.end_frame
      |=> !busy ##1 !status_valid)
      else $error("end frame did not close sequence");
   chk_more_frames: assert property (
      frame_ok && !cmd_valid && !data_beat.end_frame |=> busy)
      else $error("sequence closed early");

   cov_full_pass: cover property (@(posedge mclk) disable iff (reset)
      frame_ok && data_beat.end_frame);
   cov_mismatch: cover property (@(posedge mclk) disable iff (reset)
      frame_done && data_beat.checksum_ok && frame_bad);
   cov_param: cover property (@(posedge mclk) disable iff (reset)
      state_q == ST_IDLE && cmd_valid && param_bad);
   cov_two_frames: cover property (@(posedge mclk) disable iff (reset)
      frame_ok && !data_beat.end_frame ##[1:600] frame_ok);
   cov_abort: cover property (@(posedge mclk) disable iff (reset)
      state_q == ST_DATA && cmd_valid);
endmodule // flash_verify_command_sequencer

// File: verification/flash_programmer_model.sv
// Programmer side of the frame link, driving at the falling edge
`timescale 1ns/1ps
module flash_programmer_model
   import verify_seq_pkg::*;
(
   input wire logic mclk, // Bench clock
   output logic cmd_valid, // Command pulse
   output cmd_frame_t cmd_frame, // Decoded command
   output logic data_valid, // Byte pulse
   output data_beat_t data_beat // Byte and flags
);
   initial begin
      cmd_valid = 1'b0;
      data_valid = 1'b0;
      cmd_frame = '0;
      data_beat = '0;
   end
   // Six parameter bytes arrive as two addresses
   task automatic send_cmd(input cmd_frame_t f);
      @(negedge mclk);
      cmd_frame <= f;
      cmd_valid <= 1'b1;
   endtask
   task automatic send_beat(input data_beat_t b);
      @(negedge mclk);
      data_beat <= b;
      data_valid <= 1'b1;
   endtask
   // Gap cycle; stale fields flip so they never look valid
   task automatic idle();
      @(negedge mclk);
      cmd_valid <= 1'b0;
      data_valid <= 1'b0;
      cmd_frame <= ~cmd_frame;
      data_beat <= ~data_beat;
   endtask
endmodule // flash_programmer_model

// File: verification/tb_flash_verify_command_sequencer.sv
// Self-checking bench for the verify command sequencer
`timescale 1ns/1ps
`include "verify_seq_params.svh"
module tb_flash_verify_command_sequencer;
   import verify_seq_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid, data_valid, status_valid, busy;
   cmd_frame_t cmd_frame;
   data_beat_t data_beat;
   status_frame_t status_frame;
   logic [7:0] flash_rdata, key;
   logic [`ADDR_W-1:0] flash_addr, a, e_q;
   int n_mismatch = 0;
   int num_checks = 0;
   always #50 mclk = ~mclk;
   function automatic logic [7:0] fl(input logic [`ADDR_W-1:0] x);
      return x[7:0] ^ x[15:8] ^ key;
   endfunction
   assign flash_rdata = fl(flash_addr);
   flash_programmer_model prog (.mclk(mclk), .cmd_valid(cmd_valid),
      .cmd_frame(cmd_frame), .data_valid(data_valid),
      .data_beat(data_beat));
   flash_verify_command_sequencer dut (.mclk(mclk), .reset(reset),
      .cmd_valid(cmd_valid), .cmd_frame(cmd_frame),
      .data_valid(data_valid), .data_beat(data_beat),
      .flash_rdata(flash_rdata), .flash_addr(flash_addr),
      .status_valid(status_valid), .status_frame(status_frame),
      .busy(busy));
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic chk_st(input logic [7:0] s1, s2, input logic two, b);
      check(status_valid === 1'b1, "no status");
      check(status_frame.first_status_byte === s1, "first byte");
      check(status_frame.second_status_byte === s2, "second");
      check(status_frame.two_bytes === two, "status length");
      check(busy === b, "busy");
   endtask
   task automatic cmd(input logic [`ADDR_W-1:0] s, e, input logic [2:0] ok);
      logic [7:0] x;
      x = (!ok[2] || !ok[1]) ? `CODE_NACK : !ok[0] ? `CODE_CSUM :
         (s % 4096 != 0 || e % 4096 != 4095 || e < s) ? `CODE_PARAM :
         `CODE_ACK;
      prog.send_cmd({s, e, ok});
      prog.idle();
      chk_st(x, `ZERO_CODE, 1'b0, x == `CODE_ACK);
      a = s;
      e_q = e;
   endtask
   // Model: bad byte, byte past end, or short end frame all mismatch
   task automatic frame(input int n, bad, input logic ck, endf);
      logic mis, over;
      logic [7:0] c;
      mis = 1'b0;
      over = 1'b0;
      for (int i = 0; i < n; i++) begin
         prog.send_beat({fl(a) ^ 8'(i == bad), i == n - 1, endf, ck});
         check(flash_addr === a, "address");
         mis |= (i == bad) | over;
         over = (a == e_q);
         if (!over) a++;
      end
      mis |= endf & !over;
      c = !ck ? `CODE_CSUM : mis ? `CODE_MISMATCH : `CODE_ACK;
      prog.idle();
      chk_st(`CODE_ACK, c, 1'b1, c == `CODE_ACK && !endf);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      n_mismatch++;
      close_out();
   end
   initial begin
      void'($urandom(32'h765b51ab));
      key = 8'($urandom);
      repeat (4) @(posedge mclk);
      @(negedge mclk) reset = 1'b0;
      check(busy === 1'b0 && flash_addr === '0, "reset values");
      // Beats while idle draw no reply
      prog.send_beat(11'h007);
      prog.idle();
      check(status_valid === 1'b0, "idle beat answered");
      cmd(24'h001000, 24'h001fff, 3'b011);
      cmd(24'h001000, 24'h001fff, 3'b101);
      cmd(24'h001000, 24'h001fff, 3'b110);
      cmd(24'h001001, 24'h001fff, 3'b111);
      cmd(24'h001000, 24'h002ffe, 3'b111);
      cmd(24'h002000, 24'h000fff, 3'b111);
      // Second pass sends one byte beyond the end address
      for (int r = 0; r < 2; r++) begin
         cmd(24'h003000, 24'h003fff, 3'b111);
         for (int k = 0; k < 16; k++)
            frame(256 + r * (k == 15), -1, 1'b1, k == 15);
      end
      cmd(24'h004000, 24'h005fff, 3'b111);
      frame(256, -1, 1'b1, 1'b0);
      frame(256, $urandom_range(255), 1'b1, 1'b0);
      // Wrong byte on the very last beat of a frame
      cmd(24'h004000, 24'h004fff, 3'b111);
      frame(5, 4, 1'b1, 1'b0);
      cmd(24'h004000, 24'h004fff, 3'b111);
      frame(10, -1, 1'b0, 1'b0);
      cmd(24'h004000, 24'h004fff, 3'b111);
      frame(100, -1, 1'b1, 1'b1);
      cmd(24'h004000, 24'h004fff, 3'b111);
      prog.send_beat({fl(a), 3'b001});
      prog.idle();
      // New command mid-frame closes the data phase silently
      prog.send_cmd({24'h004000, 24'h004fff, 3'b111});
      prog.idle();
      check(status_valid === 1'b0 && busy === 1'b0, "abort");
      // Reset inside the data phase drops it with no reply
      cmd(24'h004000, 24'h004fff, 3'b111);
      @(negedge mclk) reset = 1'b1;
      @(negedge mclk) reset = 1'b0;
      check(busy === 1'b0 && status_frame === '0, "mid-run reset");
      check(status_valid === 1'b0, "reply after reset");
      cmd(24'h001000, 24'h001fff, 3'b111);
      close_out();
   end
endmodule // tb_flash_verify_command_sequencer
